/* scu_defs.svh */
// Purpose: Offsets, field positions and reset values of the system
//          configuration unit.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes:   Definitions only.
`ifndef SCU_DEFS_SVH
`define SCU_DEFS_SVH

`define SCU_ADR_W 8
`define SCU_OFS_REMAP_FILTER 8'h00
`define SCU_OFS_BREAK_ROUTE 8'h18

`define SCU_MEM_MODE_LSB 0
`define SCU_MEM_MODE_MSB 1
`define SCU_FILT_LSB 18
`define SCU_FILT_MSB 30
`define SCU_FILT_N 13

`define SCU_CORE_LOCKUP_BREAK_LOCK_BIT 0
`define SCU_VOLTAGE_DETECTOR_BREAK_LOCK_BIT 2
`define SCU_C1_ADV_BIT 3
`define SCU_C2_ADV_BIT 4
`define SCU_C1_GEN1_BIT 5
`define SCU_C2_GEN1_BIT 6
`define SCU_C1_GEN2_BIT 7
`define SCU_C2_GEN2_BIT 8
`define SCU_ETR_LSB 9
`define SCU_ETR_MSB 10

`define SCU_REMAP_FILTER_RST 32'h0000_0000
`define SCU_BREAK_ROUTE_RST 32'h0000_0000
`define SCU_ROUTE_RW_MASK 32'h0000_07f8
`define SCU_ROUTE_SET_MASK 32'h0000_0005
`define SCU_ZERO_WORD 32'h0000_0000

`endif

/* scu_pkg.sv */
// Purpose: Types shared by the system configuration unit.
// Assumes: Constants come from scu_defs.svh.
// Notes:   Types only.
package scu_pkg;

   // Memory seen at address zero
   typedef enum logic [1:0]
   {
      SCU_MAP_MAIN_FLASH = 2'h0,
      SCU_MAP_SYS_FLASH = 2'h1,
      SCU_MAP_SRAM = 2'h2
   } scu_map_t;

   // Advanced timer external trigger source
   typedef enum logic [1:0]
   {
      SCU_ETR_PIN = 2'h0,
      SCU_ETR_COMP_ONE = 2'h1,
      SCU_ETR_COMP_TWO = 2'h2,
      SCU_ETR_ADC = 2'h3
   } scu_etr_t;

   // Boot-strap capture sequence
   typedef enum logic
   {
      SCU_ST_LOAD_BOOT,
      SCU_ST_RUN
   } scu_state_t;

endpackage

/* scu_top.sv */
// Purpose: System configuration unit: memory remap at address zero,
//          bus pin analog filters, advanced timer trigger source and
//          timer break routing with sticky locks.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes:   Break and trigger outputs except the trigger source select are registered, one cycle late.
`include "scu_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module scu_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`SCU_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] boot_mode_i,
   input wire logic ext_trigger_pin_i,
   input wire logic comparator_one_i,
   input wire logic comparator_two_i,
   input wire logic adc_trigger_i,
   input wire logic voltage_detector_irq_i,
   input wire logic core_lockup_i,
   output scu_pkg::scu_map_t mem_map_o,
   output logic [`SCU_FILT_N-1:0] bus_pin_analog_filter_enable_o,
   output scu_pkg::scu_etr_t advanced_timer_trigger_source_o,
   output logic advanced_timer_etr_o,
   output logic advanced_timer_break_o,
   output logic first_general_timer_break_o,
   output logic second_general_timer_break_o,
   output logic voltage_detector_enable_ro_o
);
   import scu_pkg::*;

   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;
   logic [31:0] remap_ff;
   logic [31:0] nxt_remap;
   logic [31:0] route_ff;
   logic [31:0] nxt_route;
   scu_state_t state_ff;
   scu_state_t nxt_state;
   scu_map_t map_ff;
   scu_map_t nxt_map;
   scu_etr_t etr_sel;
   logic etr_ff;
   logic nxt_etr;
   logic adv_brk_ff;
   logic nxt_adv_brk;
   logic gen1_brk_ff;
   logic nxt_gen1_brk;
   logic gen2_brk_ff;
   logic nxt_gen2_brk;
   logic req;
   logic wr_take;
   logic hit_remap;
   logic hit_route;
   logic [31:0] lane_mask;
   logic [1:0] mem_mode;
   logic common_brk;

   // Byte lanes that a write may touch
   function automatic logic [31:0] lanes(input logic [3:0] sel);
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Decode of the two-bit map select onto the region at address zero
   function automatic scu_map_t map_decode(input logic [1:0] mode);
      if (!mode[0])
      begin
         map_decode = SCU_MAP_MAIN_FLASH;
      end
      else if (!mode[1])
      begin
         map_decode = SCU_MAP_SYS_FLASH;
      end
      else
      begin
         map_decode = SCU_MAP_SRAM;
      end
   endfunction

   assign req = wb_cyc_i & wb_stb_i;
   assign hit_remap = (wb_adr_i == `SCU_OFS_REMAP_FILTER);
   assign hit_route = (wb_adr_i == `SCU_OFS_BREAK_ROUTE);
   // Write lands on the edge where the master samples ack
   assign wr_take = req & wb_we_i & ack_ff;
   assign lane_mask = lanes(wb_sel_i);
   assign mem_mode = remap_ff[`SCU_MEM_MODE_MSB:`SCU_MEM_MODE_LSB];

   // Bus answer: ack one cycle after the request, read data with it
   always_comb
   begin
      nxt_ack = req & ~ack_ff;
      nxt_rdat = rdat_ff;
      if (req & ~ack_ff)
      begin
         if (hit_remap)
         begin
            nxt_rdat = remap_ff;
         end
         else if (hit_route)
         begin
            nxt_rdat = route_ff;
         end
         else
         begin
            // Unmapped offsets read as zero and ignore writes
            nxt_rdat = `SCU_ZERO_WORD;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         rdat_ff <= `SCU_ZERO_WORD;
      end
      else
      begin
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   // Register one: map select, pin filters, plain storage elsewhere
   always_comb
   begin
      nxt_state = state_ff;
      nxt_remap = remap_ff;
      case (state_ff)
         SCU_ST_LOAD_BOOT:
         begin
            // First edge after reset release catches the boot straps
            nxt_remap[`SCU_MEM_MODE_MSB:`SCU_MEM_MODE_LSB] = boot_mode_i;
            nxt_state = SCU_ST_RUN;
         end
         SCU_ST_RUN:
         begin
            if (wr_take & hit_remap)
            begin
               // Software value wins until the next reset
               nxt_remap = (remap_ff & ~lane_mask) |
                           (wb_dat_i & lane_mask);
            end
         end
         default:
         begin
            nxt_state = SCU_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= SCU_ST_LOAD_BOOT;
         remap_ff <= `SCU_REMAP_FILTER_RST;
      end
      else
      begin
         state_ff <= nxt_state;
         remap_ff <= nxt_remap;
      end
   end

   // Register two: routing fields read/write, locks set-only
   always_comb
   begin
      nxt_route = route_ff;
      if (wr_take & hit_route)
      begin
         nxt_route = (route_ff & ~(`SCU_ROUTE_RW_MASK & lane_mask)) |
                     (wb_dat_i & `SCU_ROUTE_RW_MASK & lane_mask);
         // Lock bits only ever set; writing zero has no effect
         nxt_route = nxt_route |
                     (wb_dat_i & `SCU_ROUTE_SET_MASK & lane_mask);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         route_ff <= `SCU_BREAK_ROUTE_RST;
      end
      else
      begin
         route_ff <= nxt_route;
      end
   end

   // Map decode and trigger/break routing
   // Every output below except the trigger source select is flopped, so a source edge or a register write
   // reaches the timers one cycle later; the routing bits are read from
   // the stored register, not from the bus, so a write in flight never
   // glitches a break line.
   assign etr_sel = scu_etr_t'(route_ff[`SCU_ETR_MSB:`SCU_ETR_LSB]);
   assign common_brk =
      (route_ff[`SCU_VOLTAGE_DETECTOR_BREAK_LOCK_BIT] & voltage_detector_irq_i) |
      (route_ff[`SCU_CORE_LOCKUP_BREAK_LOCK_BIT] & core_lockup_i);

   always_comb
   begin
      nxt_map = map_decode(mem_mode);
      case (etr_sel)
         SCU_ETR_PIN:
         begin
            nxt_etr = ext_trigger_pin_i;
         end
         SCU_ETR_COMP_ONE:
         begin
            nxt_etr = comparator_one_i;
         end
         SCU_ETR_COMP_TWO:
         begin
            nxt_etr = comparator_two_i;
         end
         SCU_ETR_ADC:
         begin
            nxt_etr = adc_trigger_i;
         end
         default:
         begin
            nxt_etr = ext_trigger_pin_i;
         end
      endcase
      nxt_adv_brk =
         (route_ff[`SCU_C2_ADV_BIT] & comparator_two_i) |
         (route_ff[`SCU_C1_ADV_BIT] & comparator_one_i) |
         common_brk;
      nxt_gen1_brk =
         (route_ff[`SCU_C2_GEN1_BIT] & comparator_two_i) |
         (route_ff[`SCU_C1_GEN1_BIT] & comparator_one_i) |
         common_brk;
      nxt_gen2_brk =
         (route_ff[`SCU_C2_GEN2_BIT] & comparator_two_i) |
         (route_ff[`SCU_C1_GEN2_BIT] & comparator_one_i) |
         common_brk;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         map_ff <= SCU_MAP_MAIN_FLASH;
         etr_ff <= 1'b0;
         adv_brk_ff <= 1'b0;
         gen1_brk_ff <= 1'b0;
         gen2_brk_ff <= 1'b0;
      end
      else
      begin
         map_ff <= nxt_map;
         etr_ff <= nxt_etr;
         adv_brk_ff <= nxt_adv_brk;
         gen1_brk_ff <= nxt_gen1_brk;
         gen2_brk_ff <= nxt_gen2_brk;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign mem_map_o = map_ff;
   assign bus_pin_analog_filter_enable_o =
      remap_ff[`SCU_FILT_MSB:`SCU_FILT_LSB];
   assign advanced_timer_trigger_source_o = etr_sel;
   assign advanced_timer_etr_o = etr_ff;
   assign advanced_timer_break_o = adv_brk_ff;
   assign first_general_timer_break_o = gen1_brk_ff;
   assign second_general_timer_break_o = gen2_brk_ff;
   // Power control block must refuse detector enable writes while high
   assign voltage_detector_enable_ro_o =
      route_ff[`SCU_VOLTAGE_DETECTOR_BREAK_LOCK_BIT];

endmodule

`default_nettype wire

/* scu_top_properties.sv */
// Purpose: Port level assertions for the system configuration unit.
// Assumes: One clock, synchronous active high reset.
// Notes: Sees only the ports of scu_top; bound below.
`timescale 1ns/1ns
`default_nettype none
module scu_props
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic ext_trigger_pin_i,
   input wire logic comparator_one_i,
   input wire logic comparator_two_i,
   input wire logic adc_trigger_i,
   input wire logic voltage_detector_irq_i,
   input wire logic core_lockup_i,
   input wire scu_pkg::scu_map_t mem_map_o,
   input wire scu_pkg::scu_etr_t advanced_timer_trigger_source_o,
   input wire logic advanced_timer_etr_o,
   input wire logic advanced_timer_break_o,
   input wire logic first_general_timer_break_o,
   input wire logic second_general_timer_break_o,
   input wire logic voltage_detector_enable_ro_o
);
   import scu_pkg::*;
   logic [1:0] s;
   logic brk;
   assign s = advanced_timer_trigger_source_o;
   assign brk = advanced_timer_break_o | first_general_timer_break_o
      | second_general_timer_break_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i)
      && $past(wb_stb_i)) else $error("ack without request");
   chk_lock_sticky: assert property (voltage_detector_enable_ro_o
      |=> voltage_detector_enable_ro_o) else $error("lock cleared");
   chk_lock_breaks: assert property (voltage_detector_enable_ro_o
      && voltage_detector_irq_i |=> advanced_timer_break_o
      && first_general_timer_break_o && second_general_timer_break_o)
      else $error("detector not routed");
   chk_map_legal: assert property (mem_map_o != 2'h3)
      else $error("bad map code");
   chk_quiet_breaks: assert property (!comparator_one_i && !comparator_two_i
      && !voltage_detector_irq_i && !core_lockup_i |=> !brk)
      else $error("break without source");
   chk_etr_select: assert property (!$past(rst_i) && !$past(rst_i, 2)
      |-> advanced_timer_etr_o == ($past(s) == 2'h0 ?
      $past(ext_trigger_pin_i) : $past(s) == 2'h1 ? $past(comparator_one_i)
      : $past(s) == 2'h2 ? $past(comparator_two_i) : $past(adc_trigger_i)))
      else $error("trigger select wrong");
endmodule
bind scu_top scu_props i_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .ext_trigger_pin_i(ext_trigger_pin_i), .adc_trigger_i(adc_trigger_i),
   .comparator_one_i(comparator_one_i), .core_lockup_i(core_lockup_i),
   .comparator_two_i(comparator_two_i), .mem_map_o(mem_map_o),
   .voltage_detector_irq_i(voltage_detector_irq_i),
   .advanced_timer_trigger_source_o(advanced_timer_trigger_source_o),
   .advanced_timer_etr_o(advanced_timer_etr_o),
   .advanced_timer_break_o(advanced_timer_break_o),
   .first_general_timer_break_o(first_general_timer_break_o),
   .second_general_timer_break_o(second_general_timer_break_o),
   .voltage_detector_enable_ro_o(voltage_detector_enable_ro_o));
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the system configuration unit.
// Assumes: Classic Wishbone master, sources driven at the rising edge.
// Notes: Register model kept in r1 and r2.
`include "scu_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   import scu_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ack, c1, c2, pin, adc, irq, lk;
   logic adv, g1, g2, external_trigger_input, ro;
   logic [1:0] boot;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [12:0] filt;
   logic [31:0] dat, dout, q, r1, r2, v, w;
   scu_map_t map;
   scu_etr_t src;
   int errors = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'h0000_50ea;
   scu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .boot_mode_i(boot),
      .ext_trigger_pin_i(pin), .comparator_one_i(c1),
      .comparator_two_i(c2), .adc_trigger_i(adc),
      .voltage_detector_irq_i(irq), .core_lockup_i(lk), .mem_map_o(map),
      .bus_pin_analog_filter_enable_o(filt),
      .advanced_timer_trigger_source_o(src), .advanced_timer_etr_o(external_trigger_input),
      .advanced_timer_break_o(adv), .first_general_timer_break_o(g1),
      .second_general_timer_break_o(g2), .voltage_detector_enable_ro_o(ro));
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'h3, wr, a, d, s};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 10);
      q = dout;
      {cyc, stb} <= 2'h0;
      if (ack !== 1'b1)
      begin
         errors++;
         finish_test();
      end
      if (wr && a == 8'h00)
         r1 = (r1 & ~m) | (d & m);
      if (wr && a == 8'h18)
         r2 = (r2 & ~(`SCU_ROUTE_RW_MASK & m)) | (d & m &
            (`SCU_ROUTE_RW_MASK | `SCU_ROUTE_SET_MASK));
   endtask
   task automatic chk_all();
      logic lo;
      logic [3:0] t;
      v = rnd();
      @(posedge clk_i);
      {c1, c2, pin, adc, irq, lk} <= v[5:0];
      repeat (3) @(posedge clk_i);
      lo = v[1] & r2[2] | v[0] & r2[0];
      t = {v[2], v[4], v[5], v[3]};
      cmp(adv, v[5] & r2[3] | v[4] & r2[4] | lo);
      cmp(g1, v[5] & r2[5] | v[4] & r2[6] | lo);
      cmp(g2, v[5] & r2[7] | v[4] & r2[8] | lo);
      cmp(src, r2[10:9]);
      cmp(external_trigger_input, t[r2[10:9]]);
      cmp(ro, r2[2]);
      cmp(filt, r1[30:18]);
      cmp(map, r1[0] ? (r1[1] ? 32'h2 : 32'h1) : 32'h0);
   endtask
   task automatic rst_run(input logic [1:0] b);
      @(posedge clk_i);
      {rst_i, boot} <= {1'b1, b};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      r1 = {30'h0, b};
      r2 = 32'h0;
   endtask
   initial
   begin
      {rst_i, cyc, stb, we, adr, sel, dat, boot} = {1'b1, 48'h0};
      {c1, c2, pin, adc, irq, lk} = 6'h0;
      for (int b = 0; b < 4; b++)
      begin
         rst_run(b[1:0]);
         wb(1'b0, 8'h00, 32'h0, 4'hf);
         cmp(q, r1);
         chk_all();
      end
      for (int i = 0; i < 12; i++)
      begin
         w = rnd();
         wb(1'b1, 8'h00, rnd(), w[3:0]);
         v = rnd();
         wb(1'b1, 8'h18, i < 8 ? v & ~32'h5 : v, w[7:4]);
         chk_all();
         wb(1'b0, 8'h18, 32'h0, 4'hf);
         cmp(q, r2);
         wb(1'b0, 8'h00, 32'h0, 4'hf);
         cmp(q, r1);
      end
      wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      cmp(q, 32'h0);
      wb(1'b1, 8'h18, 32'h5, 4'hf);
      wb(1'b1, 8'h18, 32'h0, 4'hf);
      wb(1'b0, 8'h18, 32'h0, 4'hf);
      cmp(q, r2);
      chk_all();
      rst_run(2'h1);
      wb(1'b0, 8'h18, 32'h0, 4'hf);
      cmp(q, 32'h0);
      chk_all();
      finish_test();
   end
endmodule
`default_nettype wire
